/* File: rtl/perf_counter_pkg.sv */
package perf_counter_pkg;
    localparam int CNT_W = 20;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL_WORD = 8'h00;
    localparam logic [7:0] ADDR_ENABLES = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_FETCH_STATUS = 8'h14;
    // control word layout
    localparam int CTL_CNT1_LSB = 0;
    localparam int CTL_CNT0_LSB = 20;
    localparam int CTL_PAIR_LSB = 40;
    localparam int CTL_SAMPLE_BIT = 42;
    // control word split: low word holds counter one and counter zero bits 11:0
    localparam int CTL_LO_CNT0_BITS = 12;
    // enables register bits
    localparam int EN_SYS_BIT = 0;
    localparam int EN_PROC_BIT = 1;
    localparam int EN_CNT0_BIT = 2;
    localparam int EN_CNT1_BIT = 3;
    localparam int EN_PRIV_BIT = 4;
    // control high word bit positions (offset 0x00 holds low half, 0x18 high half)
    localparam logic [7:0] ADDR_CTRL_HIGH = 8'h18;
    localparam int RETIRE_CAP = 8;
    localparam int FETCH_CAP = 4;
    localparam int MISS_LEAD = 3;
    localparam int WIN_OPEN_DELAY = 5;
    localparam int WIN_CLOSE_DELAY = 2;
    localparam logic [1:0] PAIR_RET_CYC = 2'h0;
    localparam logic [1:0] PAIR_CYC_ALT = 2'h1;
    localparam logic [1:0] PAIR_RET_MISS = 2'h2;
    localparam logic [1:0] PAIR_CYC_REPLAY = 2'h3;
    typedef enum logic [3:0] {
        WIN_IDLE = 4'h1,
        WIN_WAIT = 4'h2,
        WIN_OPEN = 4'h4,
        WIN_DONE = 4'h8
    } win_state_type;
endpackage : perf_counter_pkg

/* File: rtl/event_delay_line.sv */
`timescale 1ns/1ps
// fixed-length shift line for a single event bit
module event_delay_line #(
    parameter int DEPTH = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic [DEPTH-1:0] stage;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage <= '0;
        end else begin
            stage <= {stage[DEPTH-2:0], din};
        end
    end
    assign dout = stage[DEPTH-1];
endmodule : event_delay_line

/* File: rtl/retire_credit.sv */
`timescale 1ns/1ps
// caps per-cycle retire increment at CAP and carries the excess forward while take is high, clearing it otherwise
module retire_credit #(
    parameter int CAP = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] retireCount,
    input wire logic take,
    output logic [3:0] increment
);
    logic [5:0] backlog;
    logic [5:0] total;
    logic [5:0] capW;
    assign capW = 6'(CAP);
    assign total = backlog + {2'h0, retireCount};
    assign increment = (total > capW) ? 4'(CAP) : total[3:0];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            backlog <= 6'h00;
        end else if (take) begin
            backlog <= total - {2'h0, increment};
        end else begin
            backlog <= 6'h00;
        end
    end
endmodule : retire_credit

/* File: rtl/perf_event_counters.sv */
`timescale 1ns/1ps
module perf_event_counters (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] retireCount,
    input wire logic [2:0] fetchCount,
    input wire logic cacheMiss,
    input wire logic replayTrap,
    input wire logic retireDelay,
    input wire logic sampleEnd,
    output logic [1:0] counterIrq
);
    localparam int W = perf_counter_pkg::CNT_W;

    logic [W-1:0] counterZero;
    logic [W-1:0] counterOne;
    logic [1:0] eventPairSelect;
    logic samplingSelect;
    logic systemCountEnable;
    logic processCountEnable;
    logic counterZeroEnable;
    logic counterOneEnable;
    logic privilegedMode;
    logic [1:0] counterIrqEnable;
    logic [1:0] counterIrqPending;
    logic [1:0] thresholdLatch;
    logic [2:0] overcountField;
    logic zeroStopped;
    logic [2:0] winTimer;
    perf_counter_pkg::win_state_type winState;
    perf_counter_pkg::win_state_type next_winState;

    // apb decode
    wire access = psel && penable;
    wire wrStrobe = access && pwrite;
    wire hitLow = paddr == perf_counter_pkg::ADDR_CTRL_WORD;
    wire hitHigh = paddr == perf_counter_pkg::ADDR_CTRL_HIGH;
    wire hitEn = paddr == perf_counter_pkg::ADDR_ENABLES;
    wire hitIrqEn = paddr == perf_counter_pkg::ADDR_IRQ_ENABLE;
    wire hitSum = paddr == perf_counter_pkg::ADDR_IRQ_SUMMARY;
    wire hitClr = paddr == perf_counter_pkg::ADDR_IRQ_CLEAR;
    wire hitFetch = paddr == perf_counter_pkg::ADDR_FETCH_STATUS;
    wire mapped = hitLow | hitHigh | hitEn | hitIrqEn | hitSum | hitClr | hitFetch;
    wire wrLow = wrStrobe && hitLow;
    wire wrHigh = wrStrobe && hitHigh;
    wire wrCtrl = wrLow || wrHigh;
    wire wrClr = wrStrobe && hitClr;

    // low word: counter one [19:0], counter zero [11:0]
    // high word: counter zero [19:12] in 7:0, pair select 9:8, sampling bit 10
    wire [W-1:0] wrZero = wrLow ? {counterZero[19:12], pwdata[31:20]}
                                : {pwdata[7:0], counterZero[11:0]};
    wire [W-1:0] wrOne = wrLow ? pwdata[19:0] : counterOne;

    // counting gate
    wire globalEnable = systemCountEnable || processCountEnable;
    wire zeroActive = counterZeroEnable && globalEnable && !zeroStopped;
    wire oneActive = counterOneEnable && globalEnable;

    // retire credit keeps excess retires while counter zero counts; squashed ones never reach retireCount
    logic [3:0] retireInc;
    retire_credit #(
        .CAP(perf_counter_pkg::RETIRE_CAP)
    ) u_credit (
        .clk_sys(clk_sys),
        .rst(rst),
        .retireCount(retireCount),
        .take(zeroActive),
        .increment(retireInc)
    );

    // cache-miss event aligned three cycles ahead of the nominal window
    logic missLead;
    event_delay_line #(
        .DEPTH(perf_counter_pkg::MISS_LEAD)
    ) u_miss (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(cacheMiss),
        .dout(missLead)
    );

    // the window gate lags, so sampling mode counts the raw miss input in the same cycle as winOpen
    wire winOpen = winState == perf_counter_pkg::WIN_OPEN;
    wire preWindow = winState == perf_counter_pkg::WIN_IDLE;
    wire inWait = winState == perf_counter_pkg::WIN_WAIT;
    wire sampleGate = !samplingSelect || winOpen;
    wire missGate = !samplingSelect || winOpen;
    wire missEvent = samplingSelect ? cacheMiss : missLead;

    // fetch count capped at four per cycle; conditional_move halves and no-ops arrive as fetches
    wire [2:0] fetchCap = (fetchCount > 3'(perf_counter_pkg::FETCH_CAP))
                          ? 3'(perf_counter_pkg::FETCH_CAP) : fetchCount;

    // counter zero increment
    wire isRetPair = eventPairSelect == perf_counter_pkg::PAIR_RET_CYC
                     || eventPairSelect == perf_counter_pkg::PAIR_RET_MISS;
    logic [3:0] incZero;
    assign incZero = !samplingSelect ? (isRetPair ? retireInc : 4'h1)
                   : preWindow ? {1'b0, fetchCap}
                   : winOpen ? (isRetPair ? retireInc : 4'h1)
                   : 4'h0;

    // counter one increment
    logic incOne;
    always_comb begin
        case (eventPairSelect)
            perf_counter_pkg::PAIR_RET_CYC: incOne = sampleGate;
            perf_counter_pkg::PAIR_CYC_ALT: incOne = samplingSelect && winOpen && retireDelay;
            perf_counter_pkg::PAIR_RET_MISS: incOne = missGate && missEvent;
            perf_counter_pkg::PAIR_CYC_REPLAY: incOne = sampleGate && replayTrap;
            default: incOne = 1'b0;
        endcase
    end

    wire [W:0] sumZero = {1'b0, counterZero} + {{(W-3){1'b0}}, incZero};
    wire [W:0] sumOne = {1'b0, counterOne} + {{W{1'b0}}, incOne};
    wire zeroCarry = zeroActive && sumZero[W];
    wire oneCarry = oneActive && incOne && sumOne[W];

    // a write landing on a counter at its threshold arms a latched overflow
    wire zeroAtEdge = &counterZero[W-1:4];
    wire oneAtEdge = &counterOne[W-1:2];
    wire [1:0] armLatch = {wrLow && oneAtEdge, wrCtrl && zeroAtEdge};

    // sampling window sequencing
    always_comb begin
        next_winState = winState;
        case (winState)
            perf_counter_pkg::WIN_IDLE:
                if (samplingSelect && zeroCarry) next_winState = perf_counter_pkg::WIN_WAIT;
            perf_counter_pkg::WIN_WAIT:
                if (winTimer == 3'h0) next_winState = perf_counter_pkg::WIN_OPEN;
            perf_counter_pkg::WIN_OPEN:
                if (sampleEnd) next_winState = perf_counter_pkg::WIN_DONE;
            perf_counter_pkg::WIN_DONE:
                if (winTimer == 3'h0) next_winState = perf_counter_pkg::WIN_IDLE;
            default: next_winState = perf_counter_pkg::WIN_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            winState <= perf_counter_pkg::WIN_IDLE;
            winTimer <= 3'h0;
        end else if (wrCtrl) begin
            winState <= perf_counter_pkg::WIN_IDLE;
            winTimer <= 3'h0;
        end else begin
            winState <= next_winState;
            if (next_winState != winState) begin
                winTimer <= (next_winState == perf_counter_pkg::WIN_WAIT)
                    ? 3'(perf_counter_pkg::WIN_OPEN_DELAY - 2)
                    : 3'(perf_counter_pkg::WIN_CLOSE_DELAY - 1);
            end else if (winTimer != 3'h0) begin
                winTimer <= winTimer - 3'h1;
            end
        end
    end

    // counters, stop flag and overcount
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            counterZero <= '0;
            counterOne <= '0;
            zeroStopped <= 1'b0;
            overcountField <= 3'h0;
        end else begin
            if (wrCtrl) begin
                counterZero <= wrZero;
                zeroStopped <= 1'b0;
                overcountField <= 3'h0;
            end else if (zeroActive) begin
                counterZero <= sumZero[W-1:0];
                if (samplingSelect && inWait) begin
                    overcountField <= ({1'b0, overcountField} + {1'b0, fetchCap} > 4'h7) ? 3'h7
                                      : 3'(overcountField + fetchCap);
                    counterZero <= counterZero + {{(W-3){1'b0}}, fetchCap};
                end
            end
            if (samplingSelect && winState == perf_counter_pkg::WIN_DONE
                && next_winState == perf_counter_pkg::WIN_IDLE && !wrCtrl) begin
                zeroStopped <= 1'b1;
            end
            if (wrLow) begin
                counterOne <= wrOne;
            end else if (oneActive) begin
                counterOne <= sumOne[W-1:0];
            end
        end
    end

    // pending bits: hardware set wins over clear
    wire [1:0] carries = {oneCarry, zeroCarry};
    wire [1:0] setPend = carries & counterIrqEnable;
    wire [1:0] fireLatch = thresholdLatch & {2{!privilegedMode}};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            counterIrqPending <= 2'h0;
            thresholdLatch <= 2'h0;
            counterIrq <= 2'h0;
        end else begin
            counterIrqPending <= setPend | fireLatch
                | (counterIrqPending & ~({2{wrClr}} & pwdata[1:0]));
            thresholdLatch <= armLatch
                | (thresholdLatch & ~fireLatch & ~({2{wrClr}} & pwdata[1:0]));
            counterIrq <= counterIrqPending & {2{!privilegedMode}};
        end
    end

    // control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eventPairSelect <= 2'h0;
            samplingSelect <= 1'b0;
            systemCountEnable <= 1'b0;
            processCountEnable <= 1'b0;
            counterZeroEnable <= 1'b0;
            counterOneEnable <= 1'b0;
            privilegedMode <= 1'b1;
            counterIrqEnable <= 2'h0;
        end else begin
            if (wrHigh) begin
                eventPairSelect <= pwdata[9:8];
                samplingSelect <= pwdata[10];
            end
            if (wrStrobe && hitEn) begin
                systemCountEnable <= pwdata[perf_counter_pkg::EN_SYS_BIT];
                processCountEnable <= pwdata[perf_counter_pkg::EN_PROC_BIT];
                counterZeroEnable <= pwdata[perf_counter_pkg::EN_CNT0_BIT];
                counterOneEnable <= pwdata[perf_counter_pkg::EN_CNT1_BIT];
                privilegedMode <= pwdata[perf_counter_pkg::EN_PRIV_BIT];
            end
            if (wrStrobe && hitIrqEn) begin
                counterIrqEnable <= pwdata[1:0];
            end
        end
    end

    // read mux: reads show stored values (zero added increment)
    logic [31:0] readWord;
    always_comb begin
        readWord = 32'h0;
        if (hitLow) readWord = {counterZero[11:0], counterOne};
        if (hitHigh) readWord = {21'h0, samplingSelect, eventPairSelect, counterZero[19:12]};
        if (hitEn) readWord = {27'h0, privilegedMode, counterOneEnable, counterZeroEnable,
                               processCountEnable, systemCountEnable};
        if (hitIrqEn) readWord = {30'h0, counterIrqEnable};
        if (hitSum) readWord = {30'h0, counterIrqPending};
        if (hitFetch) readWord = {25'h0, winState, overcountField[2:0]};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) prdata <= readWord;
        end
    end
endmodule : perf_event_counters

/* File: tb/perf_event_counters_sva.sv */
`timescale 1ns/1ps
module perf_event_counters_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] counterIrq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic privMode;
    wire setupPhase = psel && !penable;
    wire mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'h0);
    wire doWrite = psel && penable && pready && pwrite;
    wire privWrite = doWrite && (paddr == perf_counter_pkg::ADDR_ENABLES);
    wire clrOrEn = privWrite || (doWrite && paddr == perf_counter_pkg::ADDR_IRQ_CLEAR);
    // shadow of the privileged-mode bit, tracked from bus writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            privMode <= 1'b1;
        end else if (privWrite) begin
            privMode <= pwdata[perf_counter_pkg::EN_PRIV_BIT];
        end
    end
    sequence setup_s;
        setupPhase;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    AST_ANSWER: assert property (setup_s |=> answer_s)
        else $error("pready not a one-cycle answer after setup");
    AST_READY_CAUSE: assert property (pready |-> $past(setupPhase) && psel && penable)
        else $error("pready outside access phase");
    AST_ERR_UNMAPPED: assert property (setup_s and !mapped |=> pslverr)
        else $error("unmapped address not refused");
    AST_ERR_MAPPED: assert property (setup_s and mapped |=> !pslverr)
        else $error("mapped address refused");
    AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_PRIV_MASK: assert property (privMode && $past(privMode) |-> counterIrq == 2'h0)
        else $error("counter interrupt while privileged");
    AST_IRQ_HOLD: assert property ($fell(counterIrq[0]) || $fell(counterIrq[1]) |->
        $past(clrOrEn) || $past(clrOrEn, 2))
        else $error("counter interrupt dropped without cause");
endmodule : perf_event_counters_sva

/* File: tb/perf_event_counters_tb_top.sv */
`timescale 1ns/1ps
module perf_event_counters_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, rerr, cacheMiss = 1'b0, replayTrap = 1'b0;
    logic retireDelay = 1'b0, sampleEnd = 1'b0;
    logic [3:0] retireCount = 4'h0;
    logic [2:0] fetchCount = 3'h0;
    logic [1:0] counterIrq;
    logic [19:0] c0, c1, keep;
    int err_count = 0, checks = 0, cycles = 0;
    perf_event_counters dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .retireCount(retireCount), .fetchCount(fetchCount),
        .cacheMiss(cacheMiss), .replayTrap(replayTrap), .retireDelay(retireDelay),
        .sampleEnd(sampleEnd), .counterIrq(counterIrq));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic setCtl(input logic mode, input logic [1:0] pair, input logic [19:0] v0,
        input logic [19:0] v1);
        apb(1'b1, perf_counter_pkg::ADDR_CTRL_WORD, {v0[11:0], v1});
        apb(1'b1, perf_counter_pkg::ADDR_CTRL_HIGH, {21'h0, mode, pair, v0[19:12]});
    endtask : setCtl
    task automatic getCnt;
        apb(1'b0, perf_counter_pkg::ADDR_CTRL_WORD, 32'h0);
        c1 = rdata[19:0];
        c0[11:0] = rdata[31:20];
        apb(1'b0, perf_counter_pkg::ADDR_CTRL_HIGH, 32'h0);
        c0[19:12] = rdata[7:0];
    endtask : getCnt
    // counting is enabled for exactly k+3 cycles; privileged bit stays set
    task automatic run(input logic [31:0] en, input int k);
        apb(1'b1, perf_counter_pkg::ADDR_ENABLES, en);
        repeat (k) @(posedge clk_sys);
        apb(1'b1, perf_counter_pkg::ADDR_ENABLES, 32'h10);
    endtask : run
    task automatic irqAfterExit(input logic [1:0] exp);
        apb(1'b1, perf_counter_pkg::ADDR_ENABLES, 32'h0);
        repeat (3) @(posedge clk_sys);
        check("counterIrq", {30'h0, counterIrq}, {30'h0, exp});
        apb(1'b1, perf_counter_pkg::ADDR_IRQ_CLEAR, 32'h3);
        apb(1'b1, perf_counter_pkg::ADDR_ENABLES, 32'h10);
    endtask : irqAfterExit
    initial begin
        logic [4:0] gate [4] = '{5'h19, 5'h1a, 5'h18, 5'h13};
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, perf_counter_pkg::ADDR_ENABLES, 32'h0);
        check("enables reset", rdata, 32'h10);
        apb(1'b0, perf_counter_pkg::ADDR_IRQ_SUMMARY, 32'h0);
        check("pending reset", rdata, 32'h0);
        repeat (2) setCtl(1'b0, 2'h0, 20'h0, 20'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped read", {rdata[30:0], rerr}, 32'h1);
        apb(1'b1, 8'h1c, 32'hffffffff);
        check("unmapped write", {31'h0, rerr}, 32'h1);
        $display("test registers done");
        cacheMiss <= 1'b1;
        retireCount <= 4'h2;
        for (int p = 0; p < 4; p++) begin
            setCtl(1'b0, 2'(p), 20'h0, 20'h0);
            run(32'h1d, 7);
            getCnt();
            check("cnt0 pair", c0, p[0] ? 32'd10 : 32'd20);
            if (p != 1) check("cnt1 pair", c1, p == 3 ? 32'd0 : 32'd10);
        end
        for (int g = 0; g < 4; g++) begin
            setCtl(1'b0, 2'h0, 20'h0, 20'h0);
            run({27'h0, gate[g]}, 7);
            getCnt();
            check("gated cnt1", c1, g < 2 ? 32'd10 : 32'd0);
            check("gated cnt0", c0, 32'd0);
        end
        $display("test event select done");
        retireCount <= 4'h0;
        setCtl(1'b0, 2'h0, 20'h0, 20'h0);
        apb(1'b1, perf_counter_pkg::ADDR_ENABLES, 32'h15);
        retireCount <= 4'hb;
        repeat (3) @(posedge clk_sys);
        retireCount <= 4'h0;
        repeat (10) @(posedge clk_sys);
        apb(1'b1, perf_counter_pkg::ADDR_ENABLES, 32'h10);
        getCnt();
        check("retire total", c0, 32'd33);
        $display("test retire done");
        apb(1'b1, perf_counter_pkg::ADDR_IRQ_ENABLE, 32'h2);
        setCtl(1'b0, 2'h0, 20'h0, 20'hffff8);
        run(32'h19, 7);
        getCnt();
        check("wrap cnt1", c1, 32'd2);
        apb(1'b0, perf_counter_pkg::ADDR_IRQ_SUMMARY, 32'h0);
        check("pending", rdata, 32'h2);
        check("masked irq", {30'h0, counterIrq}, 32'h0);
        irqAfterExit(2'h2);
        apb(1'b0, perf_counter_pkg::ADDR_IRQ_SUMMARY, 32'h0);
        check("pending cleared", rdata, 32'h0);
        for (int c = 0; c < 2; c++) begin
            repeat (2) setCtl(1'b0, 2'h0, 20'h0, 20'hffffc);
            if (c == 0) apb(1'b1, perf_counter_pkg::ADDR_IRQ_CLEAR, 32'h3);
            irqAfterExit(c ? 2'h2 : 2'h0);
        end
        $display("test overflow done");
        fetchCount <= 3'h5;
        setCtl(1'b1, 2'h0, 20'hfff9c, 20'h0);
        run(32'h15, 7);
        getCnt();
        check("fetch cap", c0, 32'hfffc4);
        sampleEnd <= 1'b1;
        run(32'h15, 40);
        getCnt();
        keep = c0;
        run(32'h15, 10);
        getCnt();
        check("stopped cnt0", c0, {12'h0, keep});
        apb(1'b0, perf_counter_pkg::ADDR_FETCH_STATUS, 32'h0);
        check("window closed", {28'h0, rdata[6:3]}, {28'h0, perf_counter_pkg::WIN_IDLE});
        check("overcount", {29'h0, rdata[2:0]}, 32'h7);
        $display("test sampling done");
        finish_test();
    end
endmodule : perf_event_counters_tb_top
bind perf_event_counters perf_event_counters_sva sva (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .counterIrq(counterIrq));
